// ===== logic/sbc_map.svh
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

// register byte offsets on the bus
`define SBC_OFF_DIV_LOW 8'h00
`define SBC_OFF_DIV_HIGH 8'h04
`define SBC_OFF_CTRL 8'h08
`define SBC_OFF_STATUS 8'h0C

// control register fields
`define SBC_CTRL_POL_BIT 0
`define SBC_CTRL_DBL_BIT 1
`define SBC_CTRL_SYNC_BIT 2

// divisor layout
`define SBC_DIV_WIDTH 12
`define SBC_DIV_HIGH_BITS 4

// reset values
`define SBC_DIV_RESET 12'h000
`define SBC_CTRL_RESET 3'h0

// oversampling ratios
`define SBC_RATIO_NORMAL 5'd16
`define SBC_RATIO_DOUBLE 5'd8

`endif

// ===== logic/sbc_pkg.sv
package sbc_pkg;
  typedef enum logic [1:0] {
    SBC_IDLE,
    SBC_WRITE,
    SBC_READ
  } sbc_phase_t;

  typedef enum logic {
    SBC_MODE_ASYNC,
    SBC_MODE_SYNC
  } sbc_mode_t;
endpackage : sbc_pkg

// ===== logic/sbc_sync2.sv
`timescale 1ns/1ps
// two-stage synchroniser for one pin level
module sbc_sync2 (
  input wire logic clk,
  input wire logic srst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule : sbc_sync2

// ===== logic/sbc_prescaler.sv
`timescale 1ns/1ps
`include "sbc_map.svh"
// down-counter: tick every (divisor+1) clocks, reloadable at once
module sbc_prescaler #(
  parameter int WIDTH = `SBC_DIV_WIDTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [WIDTH-1:0] divisor,
  input wire logic reload,
  output logic tick,
  output logic [WIDTH-1:0] count
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic atZero;

  assign atZero = (cnt_q == '0);
  assign cnt_d = reload ? divisor : (atZero ? divisor : cnt_q - 1'b1);
  assign count = cnt_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= atZero && !reload;
    end
  end
endmodule : sbc_prescaler

// ===== logic/sbc_baud_clock.sv
`timescale 1ns/1ps
`include "sbc_map.svh"
// How it works
// - polarity 0: transmit on rising, sample on falling; 1 swaps both
// - baud divisor is a 12-bit value, bits 11 down to 0
// - high byte holds divisor bits 11:8, low byte holds bits 7:0
// - high byte bits 7:4 reserved, read zero, software writes zeros
// - writing the low byte reloads the prescaler at once
// - double-speed changes ratio 16 to 8, ignored in synchronous mode
// - mode select: 0 asynchronous, 1 synchronous on external clock
module sbc_baud_clock (
  input wire logic clk,
  input wire logic srst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // external serial clock, a pin
  input wire logic serialClockPin,
  // timing strobes and the sync-mode level to the frame logic
  output logic bitTick,
  output logic sampleTick,
  output logic txChangeStrobe,
  output logic rxSampleStrobe,
  output logic syncModeActive
);
  // ---------------------------------------------------------------
  // bus front end
  // ---------------------------------------------------------------
  logic [7:0] addr_q;
  logic [7:0] addr_d;
  sbc_pkg::sbc_phase_t phase_q;
  sbc_pkg::sbc_phase_t phase_d;
  wire addrPhase = hsel && hready && htrans[1];
  wire wrLow = (phase_q == sbc_pkg::SBC_WRITE) && (addr_q == `SBC_OFF_DIV_LOW);
  wire wrHigh = (phase_q == sbc_pkg::SBC_WRITE) && (addr_q == `SBC_OFF_DIV_HIGH);
  wire wrCtrl = (phase_q == sbc_pkg::SBC_WRITE) && (addr_q == `SBC_OFF_CTRL);

  assign addr_d = addrPhase ? haddr : addr_q;
  assign phase_d = !addrPhase ? sbc_pkg::SBC_IDLE :
                   (hwrite ? sbc_pkg::SBC_WRITE : sbc_pkg::SBC_READ);
  // zero wait states; hsize ignored, only word transfers are used
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (srst) begin
      addr_q <= 8'h00;
      phase_q <= sbc_pkg::SBC_IDLE;
    end else begin
      addr_q <= addr_d;
      phase_q <= phase_d;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [`SBC_DIV_WIDTH-1:0] div_q;
  logic [`SBC_DIV_WIDTH-1:0] div_d;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;

  // reserved high-byte bits are simply not stored
  assign div_d[11:8] = wrHigh ? hwdata[3:0] : div_q[11:8];
  assign div_d[7:0] = wrLow ? hwdata[7:0] : div_q[7:0];
  assign ctrl_d = wrCtrl ? hwdata[2:0] : ctrl_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      div_q <= `SBC_DIV_RESET;
      ctrl_q <= `SBC_CTRL_RESET;
    end else begin
      div_q <= div_d;
      ctrl_q <= ctrl_d;
    end
  end

  wire polarity = ctrl_q[`SBC_CTRL_POL_BIT];
  wire doubleSpeed = ctrl_q[`SBC_CTRL_DBL_BIT];
  wire syncSel = ctrl_q[`SBC_CTRL_SYNC_BIT];
  sbc_pkg::sbc_mode_t mode;
  assign mode = syncSel ? sbc_pkg::SBC_MODE_SYNC : sbc_pkg::SBC_MODE_ASYNC;

  // ---------------------------------------------------------------
  // prescaler and oversampling divider
  // ---------------------------------------------------------------
  logic preTick;
  logic [`SBC_DIV_WIDTH-1:0] preCount;

  // the new low byte is already in div_d during the write cycle
  sbc_prescaler #(.WIDTH(`SBC_DIV_WIDTH)) uPre (
    .clk(clk),
    .srst(srst),
    .divisor(div_d),
    .reload(wrLow),
    .tick(preTick),
    .count(preCount)
  );

  logic [4:0] over_q;
  logic [4:0] over_d;
  logic bit_q;
  wire [4:0] ratio = doubleSpeed ? `SBC_RATIO_DOUBLE : `SBC_RATIO_NORMAL;
  wire overWrap = preTick && (over_q == ratio - 5'd1);

  // rate = clk / (ratio * (divisor + 1))
  assign over_d = wrLow ? 5'd0 : (overWrap ? 5'd0 : (preTick ? over_q + 5'd1 : over_q));

  always_ff @(posedge clk) begin
    if (srst) begin
      over_q <= 5'd0;
      bit_q <= 1'b0;
    end else begin
      over_q <= over_d;
      bit_q <= overWrap && (mode == sbc_pkg::SBC_MODE_ASYNC);
    end
  end

  assign bitTick = bit_q;
  assign sampleTick = preTick && (mode == sbc_pkg::SBC_MODE_ASYNC);

  // ---------------------------------------------------------------
  // external serial clock edges
  // ---------------------------------------------------------------
  logic pinSync;
  logic pinPrev_q;
  logic txStb_q;
  logic rxStb_q;

  sbc_sync2 uSync (
    .clk(clk),
    .srst(srst),
    .asyncIn(serialClockPin),
    .syncOut(pinSync)
  );

  wire rise = pinSync && !pinPrev_q;
  wire fall = !pinSync && pinPrev_q;
  // polarity only takes effect in synchronous mode; software keeps it zero otherwise
  wire txEdge = polarity ? fall : rise;
  wire rxEdge = polarity ? rise : fall;

  always_ff @(posedge clk) begin
    if (srst) begin
      pinPrev_q <= 1'b0;
      txStb_q <= 1'b0;
      rxStb_q <= 1'b0;
    end else begin
      pinPrev_q <= pinSync;
      txStb_q <= txEdge && (mode == sbc_pkg::SBC_MODE_SYNC);
      rxStb_q <= rxEdge && (mode == sbc_pkg::SBC_MODE_SYNC);
    end
  end

  assign txChangeStrobe = txStb_q;
  assign rxSampleStrobe = rxStb_q;
  assign syncModeActive = syncSel;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire [31:0] statusWord = {15'h0000, over_q, preCount};

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (addrPhase && !hwrite) begin
      case (haddr)
        `SBC_OFF_DIV_LOW: rdata_d = {24'h00_0000, div_q[7:0]};
        `SBC_OFF_DIV_HIGH: rdata_d = {28'h000_0000, div_q[11:8]};
        `SBC_OFF_CTRL: rdata_d = {29'h0000_0000, ctrl_q};
        `SBC_OFF_STATUS: rdata_d = statusWord;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
endmodule : sbc_baud_clock

// ===== test/sbc_sva.sv
`timescale 1ns/1ps
module sbc_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic serialClockPin,
  input wire logic bitTick,
  input wire logic sampleTick,
  input wire logic txChangeStrobe,
  input wire logic rxSampleStrobe,
  input wire logic syncModeActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or erred");
  chk_async_quiet: assert property (
    !syncModeActive && !$past(syncModeActive) |-> !txChangeStrobe && !rxSampleStrobe)
    else $error("edge strobe in async mode");
  chk_sample_sync: assert property (syncModeActive |-> !sampleTick)
    else $error("sample tick in sync mode");
  chk_bit_sync: assert property (syncModeActive && $past(syncModeActive) |-> !bitTick)
    else $error("bit tick in sync mode");
  chk_edge_strobe: assert property (
    syncModeActive && $changed(serialClockPin) |-> ##3 (txChangeStrobe ^ rxSampleStrobe))
    else $error("pin edge gave no single strobe");
  chk_strobe_cause: assert property (
    txChangeStrobe || rxSampleStrobe |-> $past(serialClockPin, 4) != $past(serialClockPin, 3))
    else $error("strobe without pin edge");
  chk_tx_pulse: assert property (txChangeStrobe |=> !txChangeStrobe)
    else $error("transmit strobe too long");
  chk_bit_spacing: assert property (bitTick |=> !bitTick [*7])
    else $error("bit ticks too close");
endmodule : sbc_sva
bind sbc_baud_clock sbc_sva sbc_sva_inst (.clk, .srst, .hreadyout, .hresp, .serialClockPin,
  .bitTick, .sampleTick, .txChangeStrobe, .rxSampleStrobe, .syncModeActive);

// ===== test/sbc_far_end.sv
`timescale 1ns/1ps
module sbc_far_end (
  input wire logic clk,
  input wire logic run,
  output logic serialClockPin
);
  logic [1:0] phase;
  initial begin
    serialClockPin = 1'b0;
    phase = 2'h0;
  end
  // falling edge launch keeps the level clear of the sampling edge; idles low
  always @(negedge clk) begin
    phase <= phase + 2'h1;
    if (phase == 2'h3 && (run || serialClockPin)) serialClockPin <= ~serialClockPin;
  end
endmodule : sbc_far_end

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk, srst, hsel, hwrite, hreadyout, hresp, run, serialClockPin, pol, dbl;
  logic bitTick, sampleTick, txChangeStrobe, rxSampleStrobe, syncModeActive;
  logic [1:0] htrans;
  logic [7:0] haddr;
  logic [11:0] d;
  logic [31:0] hwdata, hrdata, rd;
  int fail_count, checks_done, seed, txSeen;
  sbc_baud_clock sbc_baud_clock_inst (.clk, .srst, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .serialClockPin, .bitTick, .sampleTick, .txChangeStrobe, .rxSampleStrobe,
    .syncModeActive);
  sbc_far_end sbc_far_end_inst (.clk, .run, .serialClockPin);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  // b selects bit tick; first wait bounds reload, second measures period
  task automatic gap(input logic b, input int e);
    int n;
    n = 0;
    while ((b ? bitTick : sampleTick) !== 1'b1 && n < 9000) begin
      @(posedge clk);
      n++;
    end
    check(n <= e + 1, 1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((b ? bitTick : sampleTick) !== 1'b1 && n < 9000);
    check(n, e);
  endtask : gap
  always @(posedge clk) begin
    if (txChangeStrobe) begin
      txSeen++;
      check(serialClockPin, !pol);
    end
    if (rxSampleStrobe) check(serialClockPin, pol);
  end
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2_000_000;
    fail_count++;
    summarize;
  end
  initial begin
    {srst, hsel, hwrite, htrans, haddr, hwdata, run, pol, txSeen} = '0;
    srst = 1'b1;
    seed = 32'hf6ba;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int a = 0; a < 20; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      if (a != 12) check(rd, 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      d = (i == 1) ? 12'hfff : (i == 0) ? 12'h000 : 12'h03f & $random(seed);
      dbl = $random(seed);
      bus(1'b1, 8'h08, {30'h0, dbl, 1'b0});
      bus(1'b1, 8'h04, 32'hf);
      bus(1'b1, 8'h00, 32'hff);
      bus(1'b1, 8'h04, {28'h0, d[11:8]});
      bus(1'b1, 8'h00, {24'h0, d[7:0]});
      gap(1'b0, d + 1);
      if (d < 64) gap(1'b1, (dbl ? 8 : 16) * (d + 1));
      bus(1'b0, 8'h04, 32'h0);
      check(rd, {28'h0, d[11:8]});
      bus(1'b0, 8'h00, 32'h0);
      check(rd, {24'h0, d[7:0]});
    end
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      bus(1'b1, 8'h08, {29'h0, 2'h2, p[0]});
      @(posedge clk);
      check(syncModeActive, 1);
      txSeen = 0;
      run <= 1'b1;
      repeat (80) @(posedge clk);
      run <= 1'b0;
      repeat (20) @(posedge clk);
      check(txSeen > 3, 1);
    end
    bus(1'b1, 8'h08, 32'h0);
    @(posedge clk);
    check(syncModeActive, 0);
    summarize;
  end
endmodule : tb_top
